// ### rtl/autocal_pkg.sv
// Shared constants for the autocalibration run controller.
// Assumes a 40 MHz system clock; times are converted to cycles here.
package autocal_pkg;
  localparam int unsigned CLK_HZ            = 40000000;
  localparam int unsigned TIMEOUT_SEC       = 600;
  localparam longint unsigned TIMEOUT_CYC   = longint'(TIMEOUT_SEC) * CLK_HZ;
  // Run length in normal mode; fast mode is four times shorter
  localparam int unsigned RUN_MS_NORMAL     = 2000;
  localparam int unsigned RUN_CYC_NORMAL    = RUN_MS_NORMAL * (CLK_HZ / 1000);
  localparam int unsigned FAST_SPEEDUP      = 4;
  localparam int unsigned FAST_DRAW_RATIO   = 2;
  // Certainty in ppm; forced value on a mid-run shift
  localparam logic [31:0] ESTIMATE_CERTAINTY_SHIFT_PPM    = 32'h0000_C351;
  localparam logic [31:0] ESTIMATE_CERTAINTY_RST          = 32'hFFFF_FFFF;
  localparam logic [31:0] CC_RST            = 32'h0000_0000;
  // Config field positions
  localparam int unsigned CFG_W             = 8;
  localparam int unsigned CFG_START_BIT     = 0;
  localparam int unsigned CFG_MODE_BIT      = 1;
  localparam int unsigned CFG_CH_LSB        = 2;
  localparam int unsigned CFG_CH_MSB        = 3;
  localparam int unsigned CFG_RSV_LSB       = 4;
  // Status bit positions
  localparam int unsigned ST_CONFERR        = 0;
  localparam int unsigned ST_ABSENT         = 1;
  localparam int unsigned ST_TIMEOUT        = 2;
  localparam int unsigned ST_SHIFT          = 3;
  localparam int unsigned ST_W              = 4;
  localparam logic [ST_W-1:0] STATUS_RST    = 4'h0;
  localparam int unsigned NUM_CH            = 3;
  typedef enum logic [1:0] {
    CH_SHUNT  = 2'h0,
    CH_XFMR   = 2'h1,
    CH_VOLT   = 2'h2,
    CH_NONE   = 2'h3
  } chan_t;
  typedef enum logic {
    MODE_NORMAL = 1'b0,
    MODE_FAST   = 1'b1
  } pmode_t;
endpackage

// ### rtl/autocal_sync.sv
// Two-stage synchroniser for asynchronous pin levels.
// Assumes the destination runs on ref_clk_in.
`timescale 1ns/1ps
module autocal_sync #(
  parameter int unsigned  W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         ref_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// ### rtl/autocal_timer.sv
// Loadable down counter with a one-cycle expiry pulse.
// Assumes load and run come from logic on the same clock.
`timescale 1ns/1ps
module autocal_timer #(
  parameter int unsigned W = 36
) (
  input  wire logic         ref_clk_in,
  input  wire logic         sys_rst_in,
  input  wire logic         load_in,
  input  wire logic [W-1:0] value_in,
  input  wire logic         run_in,
  output logic              expire_out
);
  logic [W-1:0] cnt_q, cnt_d;
  logic         exp_q, exp_d;

  if (W < 2) begin
    $error("timer width too small");
  end

  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (load_in) begin
      cnt_d = value_in;
    end else if (run_in && cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
      exp_d = (cnt_q == W'(1));
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expire_out = exp_q;
endmodule

// ### rtl/autocal_run_control.sv
// Autocalibration run sequencer: one channel at a time, two power modes,
// per-channel certainty and conversion constant, sticky warning flags.
// Assumes an estimator engine on the same clock supplies estimates and
// a reference-detect pin arrives asynchronously.
`timescale 1ns/1ps
// Notes on behaviour
// - Both current channels calibrate in fast or normal
// - Fast mode run ends four times sooner
// - One channel at a time, started by config write
// - A run lasts a fixed run time or ends early on a stop write
// - Certainty in ppm, smaller means more confident
// - Constant in amps or volts per code
// - Warnings held as bits of one status register
// - Invalid config at start sets config error
// - Missing reference signal sets absent flag
// - Run active beyond 600 s sets timeout
// - Mid-run constant change sets shift flag
// - Shift forces certainty above 50,000 ppm
// - Active-low interrupt output for enabled events
module autocal_run_control
  import autocal_pkg::*;
#(
  parameter int unsigned     RUN_CYCLES  = RUN_CYC_NORMAL,
  parameter longint unsigned TIMEOUT_CYC_P = TIMEOUT_CYC,
  parameter int unsigned     DATA_W      = 32
) (
  // Clock and reset
  input  wire logic              ref_clk_in,
  input  wire logic              sys_rst_in,
  // Host configuration
  input  wire logic              cfg_wr_in,
  input  wire logic [CFG_W-1:0]  cfg_data_in,
  input  wire logic              status_clr_in,
  input  wire logic [ST_W-1:0]   status_clr_mask_in,
  input  wire logic [ST_W-1:0]   irq_enable_in,
  // Estimator engine and reference-detect pin
  input  wire logic              est_valid_in,
  input  wire logic [DATA_W-1:0] est_cc_in,
  input  wire logic [DATA_W-1:0] est_estimate_certainty_in,
  input  wire logic              est_shift_in,
  input  wire logic              ref_present_pin_in,
  // Run status
  output logic                   run_active_out,
  output logic [1:0]             run_channel_out,
  output logic                   fast_mode_out,
  output logic                   run_done_out,
  output logic [ST_W-1:0]        autocal_warning_status_out,
  output logic                   irq_n_out,
  // Per-channel results
  output logic [DATA_W-1:0]      estimate_certainty_shunt_out,
  output logic [DATA_W-1:0]      estimate_certainty_xfmr_out,
  output logic [DATA_W-1:0]      estimate_certainty_volt_out,
  output logic [DATA_W-1:0]      cc_shunt_out,
  output logic [DATA_W-1:0]      cc_xfmr_out,
  output logic [DATA_W-1:0]      cc_volt_out
);
  localparam int unsigned TW = 36;

  // Elaboration checks: timers and result words cannot serve these
  if (RUN_CYCLES < FAST_SPEEDUP) begin
    $error("run length too short");
  end
  if (TIMEOUT_CYC_P < 1 || TIMEOUT_CYC_P >= (64'h1 << TW)) begin
    $error("timeout does not fit the watchdog counter");
  end
  if (DATA_W < 16 || DATA_W > 32) begin
    $error("result width out of range");
  end

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_DONE
  } run_state_t;

  function automatic logic cfg_valid(input logic [CFG_W-1:0] c);
    logic [1:0] ch;
    ch = c[CFG_CH_MSB:CFG_CH_LSB];
    // Fast mode only exists for the current channels
    cfg_valid = (c[CFG_W-1:CFG_RSV_LSB] == '0) && (ch != CH_NONE) &&
                !(c[CFG_MODE_BIT] && ch == CH_VOLT);
  endfunction

  logic ref_present;
  // Resets to present so a run started right after reset sees no false absence
  autocal_sync #(.W(1), .RST_VAL(1'b1)) u_sync (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (ref_present_pin_in),
    .sync_out   (ref_present)
  );

  run_state_t         state_q, state_d;
  logic [1:0]         ch_q, ch_d;
  logic               fast_q, fast_d;
  logic               active_q, active_d;
  logic               done_q, done_d;
  logic [ST_W-1:0]    stat_q, stat_d;
  logic [ST_W-1:0]    flag_set;
  logic               irq_n_q, irq_n_d;
  logic [DATA_W-1:0]  cc_last_q, cc_last_d;
  logic               cc_seen_q, cc_seen_d;
  logic               shifted_q, shifted_d;
  logic [DATA_W-1:0]  estimate_certainty_acc_q, estimate_certainty_acc_d;
  logic [DATA_W-1:0]  estimate_certainty_q [NUM_CH];
  logic [DATA_W-1:0]  estimate_certainty_d [NUM_CH];
  logic [DATA_W-1:0]  cc_q [NUM_CH];
  logic [DATA_W-1:0]  cc_d [NUM_CH];

  logic               run_load, run_exp, to_exp;
  logic [TW-1:0]      run_len;
  logic               start_ok, start_req, stop_req;

  assign start_req = cfg_wr_in && cfg_data_in[CFG_START_BIT];
  assign stop_req  = cfg_wr_in && !cfg_data_in[CFG_START_BIT];
  assign start_ok  = start_req && cfg_valid(cfg_data_in);
  assign run_load  = start_ok && state_q != ST_RUN;
  assign run_len   = cfg_data_in[CFG_MODE_BIT]
                   ? TW'(RUN_CYCLES / FAST_SPEEDUP)
                   : TW'(RUN_CYCLES);

  autocal_timer #(.W(TW)) u_run_timer (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .load_in    (run_load),
    .value_in   (run_len),
    .run_in     (state_q == ST_RUN),
    .expire_out (run_exp)
  );

  // Watchdog counts only while the sequencer is in ST_RUN, reloaded with the run timer on each start
  autocal_timer #(.W(TW)) u_timeout (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .load_in    (run_load),
    .value_in   (TW'(TIMEOUT_CYC_P)),
    .run_in     (state_q == ST_RUN),
    .expire_out (to_exp)
  );

  // Run sequencer: state, settings of the run and the events it raises
  always_comb begin
    state_d  = state_q;
    ch_d     = ch_q;
    fast_d   = fast_q;
    done_d   = 1'b0;
    flag_set = '0;
    if (start_req && !cfg_valid(cfg_data_in)) begin
      flag_set[ST_CONFERR] = 1'b1;
    end
    // A start while running is refused: one channel at a time
    if (start_req && state_q == ST_RUN) begin
      flag_set[ST_CONFERR] = 1'b1;
    end
    case (state_q)
      ST_IDLE, ST_DONE: begin
        state_d = ST_IDLE;
        if (start_ok) begin
          state_d = ST_RUN;
          ch_d    = cfg_data_in[CFG_CH_MSB:CFG_CH_LSB];
          fast_d  = cfg_data_in[CFG_MODE_BIT];
        end
      end
      ST_RUN: begin
        if (!ref_present) begin
          flag_set[ST_ABSENT] = 1'b1;
        end
        if (est_valid_in &&
            (est_shift_in || (cc_seen_q && est_cc_in != cc_last_q))) begin
          flag_set[ST_SHIFT] = 1'b1;
        end
        if (to_exp) begin
          flag_set[ST_TIMEOUT] = 1'b1;
        end
        // Stop beats a same-cycle expiry, so an aborted run posts nothing
        if (stop_req) begin
          state_d = ST_IDLE;
        end else if (run_exp) begin
          state_d = ST_DONE;
          done_d  = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    active_d = (state_d == ST_RUN);
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_q  <= ST_IDLE;
      ch_q     <= 2'h0;
      fast_q   <= 1'b0;
      active_q <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      ch_q     <= ch_d;
      fast_q   <= fast_d;
      active_q <= active_d;
      done_q   <= done_d;
    end
  end

  // Estimate tracking within the current run
  always_comb begin
    cc_last_d  = cc_last_q;
    cc_seen_d  = cc_seen_q;
    shifted_d  = shifted_q;
    estimate_certainty_acc_d = estimate_certainty_acc_q;
    if (run_load) begin
      // Nothing from an earlier run may leak into this one
      cc_last_d  = DATA_W'(CC_RST);
      cc_seen_d  = 1'b0;
      shifted_d  = 1'b0;
      estimate_certainty_acc_d = DATA_W'(ESTIMATE_CERTAINTY_RST);
    end else if (state_q == ST_RUN && est_valid_in) begin
      estimate_certainty_acc_d = est_estimate_certainty_in;
      cc_last_d  = est_cc_in;
      cc_seen_d  = 1'b1;
      if (flag_set[ST_SHIFT]) begin
        shifted_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cc_last_q  <= DATA_W'(CC_RST);
      cc_seen_q  <= 1'b0;
      shifted_q  <= 1'b0;
      estimate_certainty_acc_q <= DATA_W'(ESTIMATE_CERTAINTY_RST);
    end else begin
      cc_last_q  <= cc_last_d;
      cc_seen_q  <= cc_seen_d;
      shifted_q  <= shifted_d;
      estimate_certainty_acc_q <= estimate_certainty_acc_d;
    end
  end

  // Results move only when a run of their own channel completes
  always_comb begin
    estimate_certainty_d = estimate_certainty_q;
    cc_d   = cc_q;
    if (done_d) begin
      cc_d[ch_q] = cc_last_q;
      // A shifted run reports a poor certainty
      estimate_certainty_d[ch_q] = shifted_q ? DATA_W'(ESTIMATE_CERTAINTY_SHIFT_PPM) : estimate_certainty_acc_q;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        estimate_certainty_q[i] <= DATA_W'(ESTIMATE_CERTAINTY_RST);
        cc_q[i]   <= DATA_W'(CC_RST);
      end
    end else begin
      estimate_certainty_q <= estimate_certainty_d;
      cc_q   <= cc_d;
    end
  end

  // Warning flags and interrupt level
  always_comb begin
    // Hardware set wins over a same-cycle clear
    stat_d  = (stat_q & ~(status_clr_in ? status_clr_mask_in : '0)) | flag_set;
    irq_n_d = !(|(stat_d & irq_enable_in));
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      stat_q  <= STATUS_RST;
      irq_n_q <= 1'b1;
    end else begin
      stat_q  <= stat_d;
      irq_n_q <= irq_n_d;
    end
  end

  assign run_active_out             = active_q;
  assign run_channel_out            = ch_q;
  assign fast_mode_out              = fast_q;
  assign run_done_out               = done_q;
  assign autocal_warning_status_out = stat_q;
  assign irq_n_out                  = irq_n_q;
  assign estimate_certainty_shunt_out             = estimate_certainty_q[CH_SHUNT];
  assign estimate_certainty_xfmr_out              = estimate_certainty_q[CH_XFMR];
  assign estimate_certainty_volt_out              = estimate_certainty_q[CH_VOLT];
  assign cc_shunt_out               = cc_q[CH_SHUNT];
  assign cc_xfmr_out                = cc_q[CH_XFMR];
  assign cc_volt_out                = cc_q[CH_VOLT];
endmodule

// ### verification/autocal_run_control_assertions.sv
// Port checker for the autocalibration run controller.
// Assumes it is bound onto autocal_run_control with matching port names.
`timescale 1ns/1ps
module autocal_run_control_assertions
  import autocal_pkg::*;
(
  // Inputs
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        cfg_wr_in,
  input wire logic [7:0]  cfg_data_in,
  input wire logic        status_clr_in,
  input wire logic [3:0]  irq_enable_in,
  input wire logic        est_valid_in,
  input wire logic [31:0] est_cc_in,
  input wire logic        ref_present_pin_in,
  // Outputs watched
  input wire logic        run_active_out,
  input wire logic [1:0]  run_channel_out,
  input wire logic        fast_mode_out,
  input wire logic        run_done_out,
  input wire logic [3:0]  autocal_warning_status_out,
  input wire logic        irq_n_out,
  input wire logic [31:0] estimate_certainty_shunt_out,
  input wire logic [31:0] cc_shunt_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_START: assert property (cfg_wr_in && cfg_data_in[0] && !run_active_out
    && cfg_data_in[7:4] == 4'h0 && cfg_data_in[3:2] != 2'h3 && cfg_data_in[3:1] != 3'h5
    |=> run_active_out && run_channel_out == $past(cfg_data_in[3:2])
    && fast_mode_out == $past(cfg_data_in[1])) else $error("start not taken");
  AST_CONFIG_ERROR: assert property (cfg_wr_in && cfg_data_in[0]
    && (cfg_data_in[7:4] != 4'h0 || cfg_data_in[3:2] == 2'h3 || run_active_out)
    |=> autocal_warning_status_out[ST_CONFERR]) else $error("config error not flagged");
  AST_DONE_PULSE: assert property (run_done_out |=> !run_done_out)
    else $error("done longer than one cycle");
  AST_DONE_ENDS_RUN: assert property (run_done_out |-> !run_active_out
    && $past(run_active_out)) else $error("done without run end");
  AST_RESULTS_HOLD: assert property (!run_done_out |-> $stable(cc_shunt_out)
    && $stable(estimate_certainty_shunt_out)) else $error("result moved without done");
  AST_STICKY: assert property (!status_clr_in |=>
    (autocal_warning_status_out & $past(autocal_warning_status_out))
    == $past(autocal_warning_status_out)) else $error("flag dropped without clear");
  AST_IRQ: assert property ($stable(irq_enable_in) |-> irq_n_out ==
    !(|(autocal_warning_status_out & irq_enable_in))) else $error("irq level wrong");
  AST_ABSENT: assert property ((run_active_out && !ref_present_pin_in)[*4]
    |=> autocal_warning_status_out[ST_ABSENT]) else $error("absent not flagged");
  AST_SHIFT: assert property (run_active_out && $past(run_active_out) && est_valid_in
    && $past(est_valid_in) && est_cc_in != $past(est_cc_in)
    |=> autocal_warning_status_out[ST_SHIFT]) else $error("shift not flagged");
endmodule
bind autocal_run_control autocal_run_control_assertions i_chk (.*);

// ### verification/test_autocal_run_control.sv
// Self-checking bench for the autocalibration run controller.
// Assumes short run and timeout counts so the run stays brief.
`timescale 1ns/1ps
module test_autocal_run_control;
  import autocal_pkg::*;
  logic        ref_clk_in = 1'b0, sys_rst_in = 1'b1, cfg_wr_in = 1'b0;
  logic        status_clr_in = 1'b0, est_valid_in = 1'b0, est_shift_in = 1'b0;
  logic        ref_present_pin_in = 1'b1;
  logic [7:0]  cfg_data_in = 8'h00;
  logic [3:0]  status_clr_mask_in = 4'h0, irq_enable_in = 4'h0;
  logic [31:0] est_cc_in = 32'h0000_1234, est_estimate_certainty_in = 32'h0000_0064;
  logic        run_active_out, fast_mode_out, run_done_out, irq_n_out;
  logic [1:0]  run_channel_out;
  logic [3:0]  autocal_warning_status_out;
  logic [31:0] estimate_certainty_shunt_out, estimate_certainty_xfmr_out, estimate_certainty_volt_out;
  logic [31:0] cc_shunt_out, cc_xfmr_out, cc_volt_out;
  int          mismatches = 0, total_checks = 0, len_n, len_f, n;
  logic [7:0]  bad_cfg [3] = '{8'h0D, 8'h11, 8'h0B};
  // Watchdog at 30 cycles: normal runs (40) trip it, fast runs (10) do not
  autocal_run_control #(.RUN_CYCLES(40), .TIMEOUT_CYC_P(30)) i_autocal_run_control (.*);
  always #12.5 ref_clk_in = ~ref_clk_in;
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic pulse(logic wr, logic [7:0] d);
    @(negedge ref_clk_in);
    cfg_wr_in = wr;
    status_clr_in = !wr;
    cfg_data_in = d;
    status_clr_mask_in = d[3:0];
    @(negedge ref_clk_in);
    cfg_wr_in = 1'b0;
    status_clr_in = 1'b0;
  endtask
  task automatic wait_done(output int k);
    k = 1;
    while (run_done_out !== 1'b1 && k < 200) begin
      @(negedge ref_clk_in);
      k++;
    end
    check("run_done", {31'h0, run_done_out}, 32'h0000_0001);
    @(negedge ref_clk_in);
  endtask
  task automatic stat(logic [3:0] exp);
    check("status", {28'h0, autocal_warning_status_out}, {28'h0, exp});
  endtask
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    give_verdict();
  end
  initial begin
    repeat (2) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    check("estimate_certainty_shunt", estimate_certainty_shunt_out, ESTIMATE_CERTAINTY_RST);
    check("irq_n", {31'h0, irq_n_out}, 32'h0000_0001);
    est_valid_in = 1'b1;
    pulse(1'b1, 8'h01);
    wait_done(len_n);
    check("cc_shunt", cc_shunt_out, 32'h0000_1234);
    check("estimate_certainty_shunt", estimate_certainty_shunt_out, 32'h0000_0064);
    check("cc_xfmr", cc_xfmr_out, CC_RST);
    stat(4'h4);
    pulse(1'b0, 8'h04);
    est_estimate_certainty_in = 32'h0000_0065;
    pulse(1'b1, 8'h07);
    wait_done(len_f);
    check("estimate_certainty_xfmr", estimate_certainty_xfmr_out, 32'h0000_0065);
    check("fast_mode", {31'h0, fast_mode_out}, 32'h0000_0001);
    check("run_channel", {30'h0, run_channel_out}, 32'h0000_0001);
    check("len_diff", len_n - len_f, 32'h0000_001E);
    stat(4'h0);
    irq_enable_in = 4'hF;
    foreach (bad_cfg[i]) begin
      pulse(1'b1, bad_cfg[i]);
      stat(4'h1);
      check("irq_n", {31'h0, irq_n_out}, 32'h0000_0000);
      pulse(1'b1, 8'h00);
      pulse(1'b0, 8'h02);
      stat(4'h1);
      pulse(1'b0, 8'h01);
      stat(4'h0);
      check("irq_n", {31'h0, irq_n_out}, 32'h0000_0001);
    end
    est_estimate_certainty_in = 32'h0000_0099;
    pulse(1'b1, 8'h01);
    pulse(1'b1, 8'h05);
    stat(4'h1);
    check("run_active", {31'h0, run_active_out}, 32'h0000_0001);
    check("run_channel", {30'h0, run_channel_out}, 32'h0000_0000);
    pulse(1'b1, 8'h00);
    repeat (50) @(negedge ref_clk_in);
    check("stopped", {31'h0, run_active_out}, 32'h0000_0000);
    stat(4'h1);
    check("estimate_certainty_shunt", estimate_certainty_shunt_out, 32'h0000_0064);
    pulse(1'b0, 8'h0F);
    ref_present_pin_in = 1'b0;
    pulse(1'b1, 8'h01);
    wait_done(n);
    stat(4'h6);
    ref_present_pin_in = 1'b1;
    pulse(1'b0, 8'h0F);
    pulse(1'b1, 8'h09);
    repeat (5) @(negedge ref_clk_in);
    est_cc_in = 32'h0000_2000;
    wait_done(n);
    stat(4'hC);
    check("estimate_certainty_volt", estimate_certainty_volt_out, ESTIMATE_CERTAINTY_SHIFT_PPM);
    check("estimate_certainty_big", {31'h0, estimate_certainty_volt_out > 32'h0000_C350}, 32'h0000_0001);
    check("cc_volt", cc_volt_out, 32'h0000_2000);
    pulse(1'b0, 8'h0F);
    pulse(1'b1, 8'h09);
    wait_done(n);
    stat(4'h4);
    check("estimate_certainty_volt", estimate_certainty_volt_out, 32'h0000_0099);
    pulse(1'b0, 8'h0F);
    pulse(1'b1, 8'h03);
    repeat (3) @(negedge ref_clk_in);
    est_shift_in = 1'b1;
    @(negedge ref_clk_in);
    est_shift_in = 1'b0;
    wait_done(n);
    stat(4'h8);
    check("estimate_certainty_shunt", estimate_certainty_shunt_out, ESTIMATE_CERTAINTY_SHIFT_PPM);
    give_verdict();
  end
endmodule
